// >>> logic/spfc_top.sv
/*
 Self-programming flash control: control/status register, arming windows,
 temporary page buffer, flash command issue, lock/fuse/signature readout.
 Assumes the core gives single-cycle store/load strobes with pointer and data,
 and the flash array answers each command with a one-cycle done pulse.
*/
// Added by the designer: the AXI4-Lite slave port.
// Notes on behaviour
// R1 - Ready interrupt asserted while enable clear, interrupt enable and global enable set.
// R2 - Ready interrupt held off during EEPROM write or store operation.
// R3 - Section-busy bit always reads zero; writes ignored.
// R4 - Signature arm plus enable: load within three cycles returns signature byte.
// R5 - Store within four cycles after signature arm does nothing.
// R6 - Writing section-read-enable while buffer holds data clears the buffer.
// R7 - Lock arm: load within three cycles returns lock or fuse by pointer bit 0.
// R8 - Page write arm: store programs buffer into pointer page, halts core.
// R9 - Page write bit clears on completion or unused four-cycle window.
// R10 - Page erase arm: store erases pointer page, halts core.
// R11 - Page erase bit clears on completion or unused four-cycle window.
// R12 - Enable allows a store for four cycles, clears after use or lapse.
// R13 - Enable alone: store puts register pair into buffer word, pointer LSB ignored.
// R14 - Enable stays set during erase or write until done.
// R15 - Only five listed low patterns arm; others leave bits 5..0 unchanged.
// R16 - Software loads lock data in R0, writes lock pattern, stores within four.
// R17 - Zero bits 5..0 of R0 program matching lock bits; pointer ignored.
// R18 - Lock programming does not stall the core.
// R19 - EEPROM write blocks programming and lock/fuse readout.
// R20 - Pointer 1 readout gives lock bits in 5:0, upper bits undefined.
// R21 - Lock arm and enable clear after readout or window lapse.
// R22 - Pointer 0 readout gives full fuse low byte.
// R23 - Strobes are single-cycle; windows count from the register write cycle.
module spfc_top #(
    parameter int PAGE_WORDS = 32,
    parameter logic [31:0] SIG_ROW = 32'h1e5ac33c // Arbitrary value
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [spfc_pkg::SPFC_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [spfc_pkg::SPFC_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core side
    input wire logic global_int_enable,
    input wire logic eeprom_write_busy_flag,
    input wire logic spm_strobe,
    input wire logic lpm_strobe,
    input wire logic [15:0] z_pointer,
    input wire logic [7:0] r0,
    input wire logic [7:0] r1,
    output spfc_pkg::spfc_lpm_resp_type lpm_resp,
    output logic cpu_halt,
    output logic spm_ready_irq,
    // Flash array side
    output spfc_pkg::spfc_flash_cmd_type flash_cmd,
    input wire logic flash_done,
    input wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,
    output logic [15:0] buf_rd_data,
    input wire logic [5:0] lock_bits_in,
    input wire logic [7:0] fuse_low_byte
);
    import spfc_pkg::*;

    localparam int PWB = $clog2(PAGE_WORDS);

    function automatic logic pat_ok(input logic [4:0] p);
        return (p == SPFC_PAT_FILL) || (p == SPFC_PAT_ERASE) || (p == SPFC_PAT_WRITE)
            || (p == SPFC_PAT_LOCK) || (p == SPFC_PAT_RSRE);
    endfunction

    spfc_state_type state_q;
    logic [4:0] low5_q;
    logic sig_q;
    logic ie_q;
    logic [2:0] win_q;
    logic [15:0] buf_mem [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buf_vld_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    spfc_lpm_resp_type lpm_resp_q;
    spfc_flash_cmd_type flash_cmd_q;
    logic halt_q, irq_q;
    logic [15:0] buf_rd_q;

    logic armed, aw_hs, ar_hs, w_hit, r_hit, ctrl_wr, arm_wr;
    logic spm_go, lpm_go, lapse, busy_op, fill_go, fill_q;
    logic [7:0] ctrl_rd;

    assign armed = (state_q == SPFC_ARMED);
    assign aw_hs = ce & awready_q & awvalid & wvalid;
    assign ar_hs = ce & arready_q & arvalid;
    assign w_hit = (awaddr[SPFC_AW-1:2] == SPFC_CTRL_ADDR[SPFC_AW-1:2]);
    assign r_hit = (araddr[SPFC_AW-1:2] == SPFC_CTRL_ADDR[SPFC_AW-1:2]);
    assign ctrl_wr = aw_hs & w_hit & wstrb[0];
    // Arming blocked while EEPROM busy or flash operation running
    assign arm_wr = ctrl_wr & ~eeprom_write_busy_flag & (state_q != SPFC_BUSY)
        & pat_ok(wdata[4:0]); // R15 R19
    assign spm_go = ce & armed & spm_strobe & ~eeprom_write_busy_flag & ~arm_wr; // R12 R19
    // Load override only in the first three window cycles
    assign lpm_go = ce & armed & lpm_strobe & ~eeprom_write_busy_flag & ~arm_wr
        & (win_q > (SPFC_WIN_SPM - SPFC_WIN_LPM))
        & ((low5_q == SPFC_PAT_LOCK) | (sig_q & (low5_q == SPFC_PAT_FILL))); // R4 R7
    assign lapse = ce & armed & (win_q == 3'h1) & ~spm_go & ~lpm_go & ~arm_wr; // R9 R11 R12
    assign busy_op = spm_go & ~sig_q & ((low5_q == SPFC_PAT_ERASE)
        | (low5_q == SPFC_PAT_WRITE) | (low5_q == SPFC_PAT_LOCK)); // R5
    assign fill_go = spm_go & ~sig_q & (low5_q == SPFC_PAT_FILL); // R13
    assign fill_q = |buf_vld_q;
    assign ctrl_rd = {ie_q, 1'b0, sig_q, low5_q}; // R3

    // Control bits and sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SPFC_IDLE;
            low5_q <= SPFC_CTRL_RESET[4:0];
            sig_q <= SPFC_CTRL_RESET[SPFC_BIT_SIG];
            ie_q <= SPFC_CTRL_RESET[SPFC_BIT_IE];
        end else if (ce) begin
            if (ctrl_wr) begin
                ie_q <= wdata[SPFC_BIT_IE];
            end
            if (arm_wr) begin
                low5_q <= wdata[4:0];
                sig_q <= wdata[SPFC_BIT_SIG];
                state_q <= SPFC_ARMED;
            end else begin
                case (state_q)
                    SPFC_ARMED: begin
                        if (busy_op) begin
                            state_q <= SPFC_BUSY; // R14
                        end else if (spm_go || lpm_go || lapse) begin
                            low5_q <= 5'h00; // R21 R12
                            sig_q <= 1'b0;
                            state_q <= SPFC_IDLE;
                        end
                    end
                    SPFC_BUSY: begin
                        if (flash_done) begin
                            low5_q <= 5'h00; // R9 R11 R14
                            sig_q <= 1'b0;
                            state_q <= SPFC_IDLE;
                        end
                    end
                    default: begin
                        state_q <= SPFC_IDLE;
                    end
                endcase
            end
        end
    end

    // Window counter, started by the register write itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_q <= 3'h0;
        end else if (ce) begin
            if (arm_wr) begin
                win_q <= SPFC_WIN_SPM; // R23
            end else if (armed && win_q != 3'h0) begin
                win_q <= win_q - 3'h1;
            end else if (!armed) begin
                win_q <= 3'h0;
            end
        end
    end

    // Temporary page buffer; no reset, validity kept per word
    always_ff @(posedge aclk) begin
        if (ce && fill_go) begin
            buf_mem[z_pointer[PWB:1]] <= {r1, r0}; // R13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_vld_q <= '0;
        end else if (ce) begin
            if (ctrl_wr && wdata[SPFC_BIT_RSRE] && fill_q) begin
                buf_vld_q <= '0; // R6
            end else if (flash_done && state_q == SPFC_BUSY
                && low5_q == SPFC_PAT_WRITE) begin
                buf_vld_q <= '0;
            end else if (fill_go) begin
                buf_vld_q[z_pointer[PWB:1]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_rd_q <= SPFC_ERASED;
        end else if (ce) begin
            buf_rd_q <= buf_vld_q[buf_rd_idx] ? buf_mem[buf_rd_idx] : SPFC_ERASED;
        end
    end

    // Flash command issue and core halt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_cmd_q <= '0;
        end else if (ce) begin
            flash_cmd_q <= '0;
            if (busy_op) begin
                flash_cmd_q.erase <= (low5_q == SPFC_PAT_ERASE); // R10
                flash_cmd_q.write <= (low5_q == SPFC_PAT_WRITE); // R8
                flash_cmd_q.lock <= (low5_q == SPFC_PAT_LOCK); // R17
                flash_cmd_q.page <= z_pointer >> (PWB + 1);
                flash_cmd_q.lock_data <= r0; // R17
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= 1'b0;
        end else if (ce) begin
            if (busy_op && low5_q != SPFC_PAT_LOCK) begin
                halt_q <= 1'b1; // R8 R10 R18
            end else if (flash_done) begin
                halt_q <= 1'b0;
            end
        end
    end

    // Load overrides: lock, fuse or signature byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lpm_resp_q <= '0;
        end else if (ce) begin
            lpm_resp_q.valid <= lpm_go;
            if (lpm_go) begin
                if (low5_q != SPFC_PAT_LOCK) begin
                    lpm_resp_q.data <= SIG_ROW[{z_pointer[1:0], 3'h0} +: 8]; // R4
                end else if (z_pointer[0]) begin
                    lpm_resp_q.data <= {SPFC_LOCK_HI, lock_bits_in}; // R20
                end else begin
                    lpm_resp_q.data <= fuse_low_byte; // R22
                end
            end
        end
    end

    // Ready interrupt level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= ie_q & global_int_enable & ~low5_q[SPFC_BIT_EN]
                & ~eeprom_write_busy_flag & (state_q != SPFC_BUSY); // R1 R2
        end
    end

    // AXI4-Lite write channel; both address and data taken together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= SPFC_OKAY;
        end else if (ce) begin
            awready_q <= ~awready_q & awvalid & wvalid & ~bvalid_q;
            wready_q <= ~awready_q & awvalid & wvalid & ~bvalid_q;
            if (aw_hs) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_hit ? SPFC_OKAY : SPFC_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= SPFC_OKAY;
        end else if (ce) begin
            arready_q <= ~arready_q & arvalid & ~rvalid_q;
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= r_hit ? {24'h0, ctrl_rd} : 32'h0;
                rresp_q <= r_hit ? SPFC_OKAY : SPFC_SLVERR;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign lpm_resp = lpm_resp_q;
    assign flash_cmd = flash_cmd_q;
    assign cpu_halt = halt_q;
    assign spm_ready_irq = irq_q;
    assign buf_rd_data = buf_rd_q;

    // Checks; a frozen clock enable suspends them
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence s_arm;
        arm_wr;
    endsequence
    sequence s_quiet;
        (!spm_strobe && !lpm_strobe && !ctrl_wr && ce) [*4];
    endsequence

    property p_irq_en;
        low5_q[SPFC_BIT_EN] |=> !spm_ready_irq;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while enable set"); // R1

    property p_irq_ee;
        eeprom_write_busy_flag || state_q == SPFC_BUSY |=> !spm_ready_irq;
    endproperty
    a_irq_ee: assert property (p_irq_ee) else $error("irq during busy"); // R2

    property p_busy_bit;
        rvalid |-> !rdata[SPFC_BIT_BUSY];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit read as one"); // R3

    property p_lapse;
        s_arm ##1 s_quiet |=> low5_q == 5'h00 && state_q == SPFC_IDLE;
    endproperty
    a_lapse: assert property (p_lapse) else $error("window did not lapse"); // R12

    property p_sig_spm;
        armed && sig_q && spm_strobe |=> flash_cmd == '0 && $stable(buf_vld_q);
    endproperty
    a_sig_spm: assert property (p_sig_spm) else $error("store acted after sig arm"); // R5

    property p_erase;
        spm_go && !sig_q && low5_q == SPFC_PAT_ERASE |=> cpu_halt && flash_cmd.erase;
    endproperty
    a_erase: assert property (p_erase) else $error("erase not issued"); // R10

    property p_en_hold;
        state_q == SPFC_BUSY |-> low5_q[SPFC_BIT_EN];
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable dropped while busy"); // R14

    property p_bad_pat;
        state_q == SPFC_IDLE && ctrl_wr && !pat_ok(wdata[4:0]) |=> low5_q == 5'h00;
    endproperty
    a_bad_pat: assert property (p_bad_pat) else $error("bad pattern armed"); // R15

    property p_lock_nohalt;
        flash_cmd.lock |-> !cpu_halt;
    endproperty
    a_lock_nohalt: assert property (p_lock_nohalt) else $error("lock set halted core"); // R18

    property p_ee_block;
        spm_strobe && eeprom_write_busy_flag |=> flash_cmd == '0;
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("flash op during eeprom"); // R19

    property p_lock_rd;
        lpm_go && low5_q == SPFC_PAT_LOCK && z_pointer[0]
            |=> lpm_resp.valid && lpm_resp.data[5:0] == $past(lock_bits_in);
    endproperty
    a_lock_rd: assert property (p_lock_rd) else $error("lock readout wrong"); // R20

    property p_fuse_rd;
        lpm_go && low5_q == SPFC_PAT_LOCK && !z_pointer[0]
            |=> lpm_resp.data == $past(fuse_low_byte) ##1 low5_q == 5'h00;
    endproperty
    a_fuse_rd: assert property (p_fuse_rd) else $error("fuse readout wrong"); // R22
endmodule

// >>> logic/spfc_pkg.sv
/*
 Shared constants and carrier types for the self-programming flash control block.
 Assumes a single clock domain and one AXI4-Lite slave port.
*/
package spfc_pkg;
    // Register map: printed offset is an index, byte address is four times it
    localparam int SPFC_AW = 12;
    localparam logic [7:0] SPFC_CTRL_INDEX = 8'h37;
    localparam logic [SPFC_AW-1:0] SPFC_CTRL_ADDR = {2'h0, SPFC_CTRL_INDEX, 2'h0};
    localparam logic [7:0] SPFC_CTRL_RESET = 8'h00;
    // Bit positions of the control/status register
    localparam int SPFC_BIT_EN = 0;
    localparam int SPFC_BIT_SIG = 5;
    localparam int SPFC_BIT_RSRE = 4;
    localparam int SPFC_BIT_BUSY = 6;
    localparam int SPFC_BIT_IE = 7;
    // Lower-five-bit arming patterns
    localparam logic [4:0] SPFC_PAT_FILL = 5'h01;
    localparam logic [4:0] SPFC_PAT_ERASE = 5'h03;
    localparam logic [4:0] SPFC_PAT_WRITE = 5'h05;
    localparam logic [4:0] SPFC_PAT_LOCK = 5'h09;
    localparam logic [4:0] SPFC_PAT_RSRE = 5'h11;
    // Arming windows in clock cycles
    localparam logic [2:0] SPFC_WIN_SPM = 3'h4;
    localparam logic [2:0] SPFC_WIN_LPM = 3'h3;
    // Misc values
    localparam logic [1:0] SPFC_LOCK_HI = 2'h0;
    localparam logic [15:0] SPFC_ERASED = 16'hffff;
    localparam logic [1:0] SPFC_OKAY = 2'h0;
    localparam logic [1:0] SPFC_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SPFC_IDLE,
        SPFC_ARMED,
        SPFC_BUSY
    } spfc_state_type;

    typedef struct packed {
        logic erase;
        logic write;
        logic lock;
        logic [15:0] page;
        logic [7:0] lock_data;
    } spfc_flash_cmd_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } spfc_lpm_resp_type;
endpackage

// >>> bench/spfc_flash_model.sv
/*
 Behavioural flash array facing the self-programming control block.
 Assumes one command pulse at a time and answers each with a done pulse.
*/
module spfc_flash_model
    import spfc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Command side
    input wire spfc_pkg::spfc_flash_cmd_type flash_cmd,
    input wire logic [3:0] done_delay,
    output logic flash_done,
    output logic [5:0] lock_bits_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic busy_q;

    // Delay set by the bench so both prompt and slow answers are seen
    always_ff @(posedge aclk) begin
        flash_done <= 1'b0;
        if (!aresetn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            lock_bits_in <= 6'h3f;
        end else if (flash_cmd.erase || flash_cmd.write || flash_cmd.lock) begin
            busy_q <= 1'b1;
            cnt_q <= done_delay;
            if (flash_cmd.lock) begin
                lock_bits_in <= lock_bits_in & flash_cmd.lock_data[5:0];
            end
        end else if (busy_q) begin
            if (cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                flash_done <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
    // Lock bits stay readable as a level during programming
endmodule

// >>> bench/spfc_top_test.sv
/*
 Self-checking bench for the self-programming flash control block.
 Assumes the design package and the flash array model are compiled first.
*/
module spfc_top_test;
    import spfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] SIG = 32'h1e5ac33c; // Arbitrary value
    localparam logic [11:0] A = SPFC_CTRL_ADDR;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, global_int_enable, eeprom_write_busy_flag;
    logic spm_strobe, lpm_strobe, cpu_halt, spm_ready_irq, flash_done;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, d;
    logic [3:0] wstrb, done_delay;
    logic [1:0] bresp, rresp;
    logic [15:0] z_pointer, buf_rd_data;
    logic [7:0] r0, r1, fuse_low_byte;
    logic [4:0] buf_rd_idx;
    logic [5:0] lock_bits_in, exp_lock;
    logic [10:0] e;
    spfc_lpm_resp_type lpm_resp;
    spfc_flash_cmd_type flash_cmd;
    logic [10:0] axq[$];
    logic [7:0] lpq[$];
    logic [26:0] fq[$];
    logic [7:0] bad[4] = '{8'h07, 8'h02, 8'h1f, 8'h0b};
    int failures = 0;
    int checks = 0;

    spfc_top #(.PAGE_WORDS(32), .SIG_ROW(SIG)) u_spfc_top (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .global_int_enable(global_int_enable),
        .eeprom_write_busy_flag(eeprom_write_busy_flag), .spm_strobe(spm_strobe),
        .lpm_strobe(lpm_strobe), .z_pointer(z_pointer), .r0(r0), .r1(r1),
        .lpm_resp(lpm_resp), .cpu_halt(cpu_halt), .spm_ready_irq(spm_ready_irq),
        .flash_cmd(flash_cmd), .flash_done(flash_done), .buf_rd_idx(buf_rd_idx),
        .buf_rd_data(buf_rd_data), .lock_bits_in(lock_bits_in),
        .fuse_low_byte(fuse_low_byte));

    spfc_flash_model u_spfc_flash_model (.aclk(aclk), .aresetn(aresetn),
        .flash_cmd(flash_cmd), .done_delay(done_delay), .flash_done(flash_done),
        .lock_bits_in(lock_bits_in));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request held until its ready edge; response ready held until answer
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
        axq.push_back({1'b0, er, 8'h00});
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
        axq.push_back({1'b1, er, v});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
    endtask

    // One single-cycle strobe, w edges late; tail lets the window run out
    task automatic core_op(input bit st, input int w, input logic [15:0] z,
                           input logic [7:0] a0, input logic [7:0] a1);
        repeat (w) @(posedge aclk);
        z_pointer <= z;
        r0 <= a0;
        r1 <= a1;
        if (st) spm_strobe <= 1'b1;
        else lpm_strobe <= 1'b1;
        @(posedge aclk);
        spm_strobe <= 1'b0;
        lpm_strobe <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (cpu_halt === 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk(cpu_halt, 0, "halt released");
    endtask

    // Results are taken off the queues in the order they were noted
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (axq.size() == 0) chk(0, 1, "unexpected bus answer");
            else begin
                e = axq.pop_front();
                if (e[10]) begin
                    chk(rresp, e[9:8], "read response");
                    chk(rdata, {24'h0, e[7:0]}, "read data");
                end else begin
                    chk(bresp, e[9:8], "write response");
                end
            end
        end
        if (lpm_resp.valid) begin
            if (lpq.size() == 0) chk(0, 1, "unexpected load reply");
            else chk(lpm_resp.data, lpq.pop_front(), "load reply");
        end
        if (flash_cmd.erase || flash_cmd.write || flash_cmd.lock) begin
            if (fq.size() == 0) chk(0, 1, "unexpected flash command");
            else chk({flash_cmd.erase, flash_cmd.write, flash_cmd.lock,
                      flash_cmd.lock ? 16'h0 : flash_cmd.page,
                      flash_cmd.lock ? flash_cmd.lock_data : 8'h0}, fq.pop_front(), "command");
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        complete_run;
    end

    initial begin
        seed = $urandom(25);
        {aresetn, awvalid, wvalid, bready, arvalid, rready, spm_strobe, lpm_strobe} = '0;
        {global_int_enable, eeprom_write_busy_flag, awaddr, araddr, wdata, wstrb} = '0;
        {z_pointer, r0, r1, buf_rd_idx, done_delay} = '0;
        ce = 1'b1;
        fuse_low_byte = $urandom;
        exp_lock = 6'h3f;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        {bready, rready} <= 2'b11;
        @(posedge aclk);
        axi_rd(A, 8'h00, SPFC_OKAY);
        axi_rd(12'h004, 8'h00, SPFC_SLVERR);
        axi_wr(12'h004, 8'h01, SPFC_SLVERR);
        foreach (bad[i]) begin
            axi_wr(A, bad[i], SPFC_OKAY);
            axi_rd(A, 8'h00, SPFC_OKAY);
        end
        global_int_enable <= 1'b1;
        axi_wr(A, 8'hc0, SPFC_OKAY);
        axi_rd(A, 8'h80, SPFC_OKAY);
        chk(spm_ready_irq, 1, "ready irq");
        eeprom_write_busy_flag <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(spm_ready_irq, 0, "irq held off");
        axi_wr(A, 8'h05, SPFC_OKAY);
        axi_rd(A, 8'h00, SPFC_OKAY);
        eeprom_write_busy_flag <= 1'b0;
        global_int_enable <= 1'b0;
        d = $urandom;
        axi_wr(A, 8'h01, SPFC_OKAY);
        core_op(1, 0, 16'h0005, d[7:0], d[15:8]);
        buf_rd_idx <= 5'h02;
        repeat (2) @(posedge aclk);
        chk(buf_rd_data, d[15:0], "buffer word");
        axi_rd(A, 8'h00, SPFC_OKAY);
        axi_wr(A, 8'h11, SPFC_OKAY);
        repeat (2) @(posedge aclk);
        chk(buf_rd_data, 16'hffff, "buffer cleared");
        done_delay <= 4'h9;
        fq.push_back({3'b100, 16'h0005, 8'h00});
        axi_wr(A, 8'h03, SPFC_OKAY);
        core_op(1, 2, 16'h0140, 8'h00, 8'h00);
        chk(cpu_halt, 1, "halt during erase");
        axi_rd(A, 8'h03, SPFC_OKAY);
        wait_idle;
        axi_rd(A, 8'h00, SPFC_OKAY);
        done_delay <= 4'h0;
        fq.push_back({3'b010, 16'h0002, 8'h00});
        axi_wr(A, 8'h05, SPFC_OKAY);
        core_op(1, 0, 16'h0080, 8'h55, 8'haa);
        wait_idle;
        axi_rd(A, 8'h00, SPFC_OKAY);
        foreach (bad[i]) if (i < 2) begin
            axi_wr(A, i ? 8'h03 : 8'h05, SPFC_OKAY);
            core_op(1, 3, 16'h0080, 8'h00, 8'h00);
            axi_rd(A, 8'h00, SPFC_OKAY);
        end
        lpq.push_back({2'b00, exp_lock});
        axi_wr(A, 8'h09, SPFC_OKAY);
        core_op(0, 0, 16'h0001, 8'h00, 8'h00);
        lpq.push_back(fuse_low_byte);
        axi_wr(A, 8'h09, SPFC_OKAY);
        core_op(0, 1, 16'h0000, 8'h00, 8'h00);
        axi_wr(A, 8'h09, SPFC_OKAY);
        core_op(0, 2, 16'h0001, 8'h00, 8'h00);
        axi_rd(A, 8'h00, SPFC_OKAY);
        fq.push_back({3'b001, 16'h0000, 8'hf5});
        axi_wr(A, 8'h09, SPFC_OKAY);
        core_op(1, 0, 16'h0001, 8'hf5, 8'h00);
        chk(cpu_halt, 0, "no halt for lock set");
        exp_lock = 6'h35;
        lpq.push_back({2'b00, exp_lock});
        axi_wr(A, 8'h09, SPFC_OKAY);
        core_op(0, 0, 16'h0001, 8'h00, 8'h00);
        lpq.push_back(SIG[23:16]);
        axi_wr(A, 8'h21, SPFC_OKAY);
        core_op(0, 0, 16'h0002, 8'h00, 8'h00);
        axi_wr(A, 8'h21, SPFC_OKAY);
        core_op(1, 0, 16'h0000, 8'h00, 8'h00);
        axi_rd(A, 8'h00, SPFC_OKAY);
        foreach (bad[i]) if (i < 2) begin
            axi_wr(A, i ? 8'h09 : 8'h03, SPFC_OKAY);
            eeprom_write_busy_flag <= 1'b1;
            core_op(i == 0, 0, 16'h0001, 8'h00, 8'h00);
            eeprom_write_busy_flag <= 1'b0;
            axi_rd(A, 8'h00, SPFC_OKAY);
        end
        // Frozen enable must hold the window open
        fq.push_back({3'b100, 16'h0003, 8'h00});
        axi_wr(A, 8'h03, SPFC_OKAY);
        ce <= 1'b0;
        repeat (6) @(posedge aclk);
        ce <= 1'b1;
        core_op(1, 0, 16'h00c0, 8'h00, 8'h00);
        wait_idle;
        axi_rd(A, 8'h00, SPFC_OKAY);
        repeat (4) @(posedge aclk);
        chk(axq.size() + lpq.size() + fq.size(), 0, "results left over");
        complete_run;
    end
endmodule
